//--- inc/pwt_pkg.sv
/*
 * Package for the programmable waveform timer: register offsets, field
 * positions, reset values and mode codes.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package pwt_pkg;

    // register byte offsets (APB, one word each)
    localparam logic [7:0] PWT_OFS_CONTROL = 8'h00;
    localparam logic [7:0] PWT_OFS_IRQ_CTRL = 8'h04;
    localparam logic [7:0] PWT_OFS_MODE = 8'h08;
    localparam logic [7:0] PWT_OFS_OUTPUT = 8'h0C;
    localparam logic [7:0] PWT_OFS_PRESCALE = 8'h10;
    localparam logic [7:0] PWT_OFS_PRIMARY = 8'h14;
    localparam logic [7:0] PWT_OFS_SECONDARY = 8'h18;

    // timer_control fields
    localparam int PWT_CTL_RUN = 0;
    localparam int PWT_CTL_ACTIVE = 1;
    localparam int PWT_CTL_HALT = 2;
    // timer_interrupt_control fields
    localparam int PWT_IRQ_PEND = 6;
    localparam int PWT_IRQ_EN = 7;
    // timer_mode_config fields
    localparam int PWT_MODE_OP_LO = 0;
    localparam int PWT_MODE_WIDE = 2;
    localparam int PWT_MODE_RELOAD_ONLY = 3;
    localparam int PWT_MODE_SRC_LO = 4;
    localparam int PWT_MODE_GATE_OFF = 7;
    // timer_output_control fields
    localparam int PWT_OUT_POL = 0;
    localparam int PWT_OUT_PATH = 1;

    localparam logic [1:0] PWT_OPMODE_WAVE = 2'h1;
    localparam logic [2:0] PWT_SRC_F2 = 3'h3;
    localparam logic [7:0] PWT_RESET_BYTE = 8'h00;
    localparam logic [7:0] PWT_RESET_COUNT = 8'hFF;
    // system clock cycles per f2 tick
    localparam logic [7:0] PWT_F2_DIV = 8'h02;

    typedef enum logic [1:0] {
        PWT_IDLE,
        PWT_PRIMARY,
        PWT_SECONDARY
    } pwt_phase_t;

    // one APB request as seen by the register file
    typedef struct packed {
        logic wr;
        logic [7:0] ofs;
        logic [7:0] data;
    } pwt_req_t;

endpackage : pwt_pkg

//--- hw/pwt_src_tick.sv
/*
 * Count source generator: one tick per selected internal clock period.
 * Assumes the system clock drives CLK; only f2 and f1 are modelled.
 */
`timescale 1ns/1ps
module pwt_src_tick
    import pwt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] src_sel,
    input wire logic gate_off,
    output logic tick
);

    logic [7:0] div_q;
    logic [7:0] div_len;

    // other source codes fall back to the undivided clock
    assign div_len = (src_sel == PWT_SRC_F2) ? PWT_F2_DIV : 8'h01;

    // free running divider, ticks are blocked when the source is cut off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
            tick <= 1'b0;
        end else begin
            if (div_q + 8'h01 >= div_len) begin
                div_q <= 8'h00;
                tick <= !gate_off;
            end else begin
                div_q <= div_q + 8'h01;
                tick <= 1'b0;
            end
        end
    end

endmodule : pwt_src_tick

//--- hw/pwt_timer.sv
/*
 * Programmable waveform timer with APB register access.
 * Holds the register file, counters, interrupt flag and pin driver.
 * Assumes an APB master and inputs synchronous to CLK.
 * RST is asynchronous, active high; the pin is push-pull, output only.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - writing run bit 1 starts counting, 0 stops it
// - read-only active flag shows counting state, may lag run bit
// - writing halt bit 1 stops at once; halt bit reads zero
// - halt also resets counters, reloads, run, active and output
// - interrupt enable bit gates the request onto the interrupt line
// - pending flag keeps its value through stop and halt; writing 0 clears it
// - in waveform mode, secondary-period underflow raises the request
// - mode field 0 1 selects waveform generation
// - wide select picks prescaler plus counter or one 16-bit counter
// - reload-only writes update reload values, not running counters
// - source field 0 1 1 selects the f2 internal clock
// - source gate bit 1 blocks the count source
// - polarity 0: high in primary, low in secondary and stopped
// - output path 0 puts the waveform on the pin
// - prescaler counts the source, any reload value 00h to FFh
// - primary register counts prescaler underflows, full 8-bit range
// - secondary register counts prescaler underflows, full 8-bit range
// - in 16-bit mode prescaler holds low byte, periods high bytes
////////////////////////////////////////////////////////////////////////////
module pwt_timer
    import pwt_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic WAVEFORM_OUT_PIN,
    output logic TIMER_IRQ
);

    ////////////////////////////////////////////////////////////////////
    // register state

    logic count_run_request_q;
    logic count_active_flag_q;
    logic timer_irq_enable_q;
    logic timer_irq_pending_q;
    logic [7:0] mode_q;
    logic [1:0] outctl_q;
    logic [7:0] pre_reload_q;
    logic [7:0] pri_reload_q;
    logic [7:0] sec_reload_q;
    logic [7:0] pre_cnt_q;
    logic [7:0] per_cnt_q;
    pwt_phase_t phase_q;
    logic wave_q;
    pwt_req_t req;
    logic access;
    logic wr_en;
    logic halt;
    logic tick;
    logic wide_counter_sel;
    logic reload_only_write;
    logic wave_mode;
    logic pre_uf;
    logic per_uf;
    logic [15:0] cnt16;
    logic end_sec;
    logic running;
    logic addr_ok;
    logic [2:0] source_sel;
    logic source_gate_off;
    logic output_polarity_sel;
    logic output_path_sel;

    // one request word, so the decode below reads a single carrier
    assign req = {PWRITE, PADDR[7:0], PWDATA[7:0]};
    assign access = PSEL && PENABLE && PREADY;
    assign wr_en = access && req.wr && addr_ok;
    // high, misaligned or unmapped addresses are refused with an error
    assign addr_ok = (PADDR[31:8] == 24'h0) && (PADDR[1:0] == 2'h0)
        && (req.ofs <= PWT_OFS_SECONDARY);
    // halt is a write-only strobe, never stored, so it reads 0
    assign halt = wr_en && req.ofs == PWT_OFS_CONTROL
        && req.data[PWT_CTL_HALT];
    assign wide_counter_sel = mode_q[PWT_MODE_WIDE];
    assign reload_only_write = mode_q[PWT_MODE_RELOAD_ONLY];
    assign wave_mode = mode_q[PWT_MODE_OP_LO +: 2] == PWT_OPMODE_WAVE;
    assign running = count_active_flag_q && tick;

    // named mode and output fields
    assign source_sel = mode_q[PWT_MODE_SRC_LO +: 3];
    assign source_gate_off = mode_q[PWT_MODE_GATE_OFF];
    assign output_polarity_sel = outctl_q[PWT_OUT_POL];
    assign output_path_sel = outctl_q[PWT_OUT_PATH];

    ////////////////////////////////////////////////////////////////////
    // count source

    // divider runs free, so a start may wait up to one tick period
    pwt_src_tick u_src (
        .clk(CLK),
        .rst(RST),
        .src_sel(source_sel),
        .gate_off(source_gate_off),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped address

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
        end else begin
            // ready only in the access cycle, so every access takes two
            PREADY <= PSEL && !PENABLE;
        end
    end

    // answer data and error, registered with ready
    // built in the setup cycle so it stands for the whole access
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            PSLVERR <= !addr_ok;
            PRDATA <= 32'h0000_0000;
            if (!addr_ok || PWRITE) begin
                PRDATA <= 32'h0000_0000;
            end else if (req.ofs == PWT_OFS_CONTROL) begin
                PRDATA[PWT_CTL_RUN] <= count_run_request_q;
                PRDATA[PWT_CTL_ACTIVE] <= count_active_flag_q;
            end else if (req.ofs == PWT_OFS_IRQ_CTRL) begin
                PRDATA[PWT_IRQ_EN] <= timer_irq_enable_q;
                PRDATA[PWT_IRQ_PEND] <= timer_irq_pending_q;
            end else if (req.ofs == PWT_OFS_MODE) begin
                PRDATA[7:0] <= mode_q;
            end else if (req.ofs == PWT_OFS_OUTPUT) begin
                PRDATA[1:0] <= outctl_q;
            end else if (req.ofs == PWT_OFS_PRESCALE) begin
                // reload-only mode reads back the reload, else the count
                PRDATA[7:0] <= reload_only_write ? pre_reload_q : pre_cnt_q;
            end else if (req.ofs == PWT_OFS_PRIMARY) begin
                PRDATA[7:0] <= pri_reload_q;
            end else begin
                PRDATA[7:0] <= sec_reload_q;
            end
        end else begin
            PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register: run request and active flag

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            count_run_request_q <= 1'b0;
        end else if (halt) begin
            count_run_request_q <= 1'b0;
        end else if (wr_en && req.ofs == PWT_OFS_CONTROL) begin
            count_run_request_q <= req.data[PWT_CTL_RUN];
        end
    end

    // active follows the request one clock later
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            count_active_flag_q <= 1'b0;
        end else if (halt) begin
            count_active_flag_q <= 1'b0;
        end else begin
            count_active_flag_q <= count_run_request_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt control

    // enable masks only the line, pending still records each secondary-period underflow in waveform mode
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            timer_irq_enable_q <= 1'b0;
        end else if (wr_en && req.ofs == PWT_OFS_IRQ_CTRL) begin
            timer_irq_enable_q <= req.data[PWT_IRQ_EN];
        end
    end

    // an underflow in the clearing cycle wins over the clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            timer_irq_pending_q <= 1'b0;
        end else if (end_sec && wave_mode) begin
            timer_irq_pending_q <= 1'b1;
        end else if (wr_en && req.ofs == PWT_OFS_IRQ_CTRL
                && !req.data[PWT_IRQ_PEND]) begin
            timer_irq_pending_q <= 1'b0;
        end
    end

    // registered so the request line comes straight from a flip-flop
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TIMER_IRQ <= 1'b0;
        end else begin
            TIMER_IRQ <= timer_irq_pending_q && timer_irq_enable_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode and output configuration

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_q <= PWT_RESET_BYTE;
            outctl_q <= 2'h0;
        end else if (wr_en) begin
            if (req.ofs == PWT_OFS_MODE) begin
                mode_q <= req.data;
            end else if (req.ofs == PWT_OFS_OUTPUT) begin
                outctl_q <= req.data[1:0];
            end
        end
    end

    // reload values; halt returns them to their initial state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pre_reload_q <= PWT_RESET_COUNT;
            pri_reload_q <= PWT_RESET_COUNT;
            sec_reload_q <= PWT_RESET_COUNT;
        end else if (halt) begin
            pre_reload_q <= PWT_RESET_COUNT;
            pri_reload_q <= PWT_RESET_COUNT;
            sec_reload_q <= PWT_RESET_COUNT;
        end else if (wr_en) begin
            if (req.ofs == PWT_OFS_PRESCALE) begin
                pre_reload_q <= req.data;
            end else if (req.ofs == PWT_OFS_PRIMARY) begin
                pri_reload_q <= req.data;
            end else if (req.ofs == PWT_OFS_SECONDARY) begin
                sec_reload_q <= req.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counters

    // 16-bit mode: prescaler is low byte, period counter the high byte
    assign cnt16 = {per_cnt_q, pre_cnt_q};
    assign pre_uf = pre_cnt_q == 8'h00;
    assign per_uf = wide_counter_sel ? (cnt16 == 16'h0000)
        : (pre_uf && per_cnt_q == 8'h00);
    assign end_sec = running && per_uf && phase_q == PWT_SECONDARY;

    // the boundary tick itself reloads, so no tick is lost or added
    // between periods; only running ticks move the counters
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pre_cnt_q <= PWT_RESET_COUNT;
            per_cnt_q <= PWT_RESET_COUNT;
            phase_q <= PWT_IDLE;
        end else if (halt) begin
            pre_cnt_q <= PWT_RESET_COUNT;
            per_cnt_q <= PWT_RESET_COUNT;
            phase_q <= PWT_IDLE;
        end else begin
            case (phase_q)
                PWT_IDLE: begin
                    // start loads both counters, first phase primary
                    if (count_active_flag_q) begin
                        pre_cnt_q <= pre_reload_q;
                        per_cnt_q <= pri_reload_q;
                        phase_q <= PWT_PRIMARY;
                    end else if (wr_en && !reload_only_write) begin
                        // direct writes also load the stopped counter
                        if (req.ofs == PWT_OFS_PRESCALE) begin
                            pre_cnt_q <= req.data;
                        end else if (req.ofs == PWT_OFS_PRIMARY) begin
                            per_cnt_q <= req.data;
                        end
                    end
                end
                default: begin
                    // a stop keeps the counts; the next start reloads
                    if (!count_active_flag_q) begin
                        phase_q <= PWT_IDLE;
                    end else if (running && per_uf) begin
                        // period boundary: swap phase and reload
                        pre_cnt_q <= pre_reload_q;
                        per_cnt_q <= (phase_q == PWT_PRIMARY)
                            ? sec_reload_q : pri_reload_q;
                        phase_q <= (phase_q == PWT_PRIMARY)
                            ? PWT_SECONDARY : PWT_PRIMARY;
                    end else if (running && wide_counter_sel) begin
                        {per_cnt_q, pre_cnt_q} <= cnt16 - 16'h0001;
                    end else if (running && pre_uf) begin
                        pre_cnt_q <= pre_reload_q;
                        per_cnt_q <= per_cnt_q - 8'h01;
                    end else if (running) begin
                        pre_cnt_q <= pre_cnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // waveform output

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wave_q <= 1'b0;
        end else if (halt || phase_q == PWT_IDLE || !wave_mode) begin
            // other modes park the level too, never a stale phase
            wave_q <= output_polarity_sel;
        end else begin
            wave_q <= (phase_q == PWT_PRIMARY) ^ output_polarity_sel;
        end
    end

    // path 1 parks the pin at the stop level
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WAVEFORM_OUT_PIN <= 1'b0;
        end else if (!output_path_sel) begin
            WAVEFORM_OUT_PIN <= wave_q;
        end else begin
            WAVEFORM_OUT_PIN <= output_polarity_sel;
        end
    end

endmodule : pwt_timer

//--- dv/pwt_load_model.sv
/* load on the waveform pin: measures level run widths
   assumes the pin is sampled on the system clock */
`timescale 1ns/1ps
module pwt_load_model (
    input wire logic clk,
    input wire logic level,
    output int hi_w,
    output int lo_w,
    output int edges
);
    int run_len = 0;
    logic last = 1'b0;
    // a run is only stored once it ends, so a width is never partial
    always @(posedge clk) begin
        if (level !== last) begin
            if (last === 1'b1) hi_w <= run_len;
            else lo_w <= run_len;
            edges <= edges + 1;
            run_len <= 1;
        end else begin
            run_len <= run_len + 1;
        end
        last <= level;
    end
endmodule : pwt_load_model

//--- dv/pwt_timer_props.sv
/* port assertions for the waveform timer
   assumes byte data in bits 7:0 and offsets in PADDR[7:0] */
`timescale 1ns/1ps
module pwt_timer_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic WAVEFORM_OUT_PIN,
    input wire logic TIMER_IRQ
);
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (RST);
    logic wr, rd, w_ctl, w_irq, w04;
    logic en_q, pol_q, wave_q;
    logic [2:0] age_q;
    // completed accesses decoded by offset
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    assign rd = PSEL && PENABLE && PREADY && !PWRITE;
    assign w_ctl = wr && PADDR[7:0] == 8'h00;
    assign w_irq = wr && PADDR[7:0] == 8'h04;
    assign w04 = w_ctl || w_irq;
    // shadows of the few bits the checks lean on
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_q <= 1'b0;
            pol_q <= 1'b0;
            wave_q <= 1'b0;
        end else begin
            if (w_irq) en_q <= PWDATA[7];
            if (wr && PADDR[7:0] == 8'h0C) pol_q <= PWDATA[0];
            if (wr && PADDR[7:0] == 8'h08) wave_q <= PWDATA[1:0] == 2'h1;
        end
    end
    // status may lag the run bit, so it is judged only when settled
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) age_q <= 3'h0;
        else if (w_ctl) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    ////////////////////////////////////////////////////////////////
    property p_ready;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready missing");
    property p_halt_rd;
        rd && PADDR[7:0] == 8'h00 |-> !PRDATA[2];
    endproperty
    a_halt_rd: assert property (p_halt_rd) else $error("halt read 1");
    property p_status;
        rd && PADDR[7:0] == 8'h00 && age_q >= 3'h2 |-> PRDATA[1] == PRDATA[0];
    endproperty
    a_status: assert property (p_status) else $error("status off");
    property p_halt_pin;
        w_ctl && PWDATA[2] && !PWDATA[0] && !pol_q |-> ##4 !WAVEFORM_OUT_PIN;
    endproperty
    a_halt_pin: assert property (p_halt_pin) else $error("pin on");
    property p_irq_off;
        w_irq && !PWDATA[7] |-> ##2 !TIMER_IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
    property p_irq_en;
        $rose(TIMER_IRQ) |-> en_q;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq disabled");
    property p_irq_mode;
        $rose(TIMER_IRQ) |-> wave_q;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq mode");
    property p_irq_hold;
        TIMER_IRQ && !w04 && !$past(w04) |=> TIMER_IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
endmodule : pwt_timer_props

bind pwt_timer pwt_timer_props chk_u (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WAVEFORM_OUT_PIN(WAVEFORM_OUT_PIN), .TIMER_IRQ(TIMER_IRQ));

//--- dv/pwt_timer_tb.sv
/* self-checking bench for the waveform timer
   assumes the load model and the bound checker */
`timescale 1ns/1ps
module pwt_timer_tb import pwt_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pin, irq, er;
    int hi_w, lo_w, edges, cyc = 0;
    int err_count = 0;
    int num_checks = 0;

    pwt_timer dut_u (.CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WAVEFORM_OUT_PIN(pin), .TIMER_IRQ(irq));
    pwt_load_model load_u (.clk(clk), .level(pin), .hi_w(hi_w),
        .lo_w(lo_w), .edges(edges));

    ////////////////////////////////////////////////////////////////
    // clock and a watchdog so a stuck handshake still ends the run
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // one transfer; request held until ready is seen at an edge
    task automatic apb(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic poll(logic want);
        int n = 0;
        do begin
            apb(1'b0, 8'h00, 8'h00);
            n++;
        end while (rd[1] !== want && n < 20);
        chk("active flag", rd[1], want);
    endtask : poll

    // safe reprogramming order: stop, halt, mask, program, start
    task automatic setup(logic [7:0] m, p, n, s, logic ien);
        apb(1'b1, 8'h00, 8'h00);
        poll(1'b0);
        apb(1'b1, 8'h00, 8'h04);
        apb(1'b1, 8'h04, 8'h00);
        apb(1'b1, 8'h08, m);
        apb(1'b1, 8'h0C, 8'h00);
        apb(1'b1, 8'h10, p);
        apb(1'b1, 8'h14, n);
        apb(1'b1, 8'h18, s);
        repeat (2) @(posedge clk);
        apb(1'b1, 8'h04, {ien, 7'h00});
        apb(1'b1, 8'h00, 8'h01);
        poll(1'b1);
    endtask : setup

    // four edges later both stored widths belong to whole periods
    task automatic measure(int hi, int lo);
        int e0 = edges;
        int n = 0;
        while (edges < e0 + 4 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        chk("edges seen", edges - e0 >= 4, 1'b1);
        chk("high width", hi_w, hi);
        chk("low width", lo_w, lo);
    endtask : measure

    task automatic t_regs;
        logic [7:0] ofs [7];
        ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ofs[i], 8'h00);
            chk("reset value", rd, (i < 4) ? 32'h0 : 32'hFF);
        end
        apb(1'b0, 8'h1C, 8'h00);
        chk("unmapped error", er, 1'b1);
        apb(1'b1, 8'h10, 8'h5A);
        apb(1'b0, 8'h10, 8'h00);
        chk("stopped count load", rd, 32'h5A);
        apb(1'b1, 8'h00, 8'h04);
        apb(1'b0, 8'h00, 8'h00);
        chk("halt reads zero", rd, 32'h0);
    endtask : t_regs

    task automatic t_wave;
        int n = 0;
        setup(8'h39, 8'h02, 8'h03, 8'h01, 1'b1);
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("irq raised", irq, 1'b1);
        apb(1'b1, 8'h04, 8'h80);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        measure(24, 12);
        apb(1'b1, 8'h14, 8'h05);
        apb(1'b0, 8'h14, 8'h00);
        chk("primary reload", rd, 32'h05);
        measure(36, 12);
    endtask : t_wave

    task automatic t_mask;
        setup(8'h39, 8'h02, 8'h03, 8'h01, 1'b0);
        repeat (100) @(posedge clk);
        chk("irq masked", irq, 1'b0);
        apb(1'b0, 8'h04, 8'h00);
        chk("pending set", rd[6], 1'b1);
        apb(1'b1, 8'h00, 8'h04);
        repeat (4) @(posedge clk);
        chk("pin after halt", pin, 1'b0);
        apb(1'b0, 8'h00, 8'h00);
        chk("control after halt", rd, 32'h0);
        apb(1'b0, 8'h10, 8'h00);
        chk("prescale after halt", rd, 32'hFF);
        apb(1'b1, 8'h04, 8'h00);
        apb(1'b0, 8'h04, 8'h00);
        chk("pending cleared", rd, 32'h0);
    endtask : t_mask

    // wide count {period, prescale}: 0x009 and 0x109 ticks plus one
    task automatic t_wide;
        setup(8'h3D, 8'h09, 8'h00, 8'h01, 1'b1);
        measure(20, 532);
    endtask : t_wide

    task automatic t_gate;
        int e0;
        setup(8'hB9, 8'h02, 8'h03, 8'h01, 1'b1);
        repeat (10) @(posedge clk);
        e0 = edges;
        repeat (100) @(posedge clk);
        chk("edges while gated", edges - e0, 0);
        chk("irq while gated", irq, 1'b0);
    endtask : t_gate

    // inverted level first, then the pin parked at its stop level
    task automatic t_pol;
        int e0;
        setup(8'h39, 8'h02, 8'h03, 8'h01, 1'b0);
        apb(1'b1, 8'h0C, 8'h01);
        measure(12, 24);
        apb(1'b1, 8'h0C, 8'h03);
        repeat (4) @(posedge clk);
        e0 = edges;
        repeat (60) @(posedge clk);
        chk("parked edges", edges - e0, 0);
        chk("parked level", pin, 1'b1);
    endtask : t_pol

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_wave();
        t_mask();
        t_wide();
        t_gate();
        t_pol();
        end_sim();
    end
endmodule : pwt_timer_tb
